//--- logic/urs_pkg.sv
// Shared constants, field positions and carrier types for the UART
// line and modem status block.
// Assumes a 32-bit classic Wishbone host with 8-bit registers in bits 7:0.
package urs_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets (one aligned word each)
  localparam logic [7:0] URS_OFS_RX_DATA = 8'h00;
  localparam logic [7:0] URS_OFS_LINE_STATUS = 8'h04;
  localparam logic [7:0] URS_OFS_MODEM_STATUS = 8'h08;
  localparam logic [7:0] URS_OFS_SCRATCH = 8'h0C;
  localparam logic [7:0] URS_OFS_MODEM_CTRL = 8'h10;
  localparam logic [7:0] URS_OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] URS_OFS_FEATURE_CTRL = 8'h18;
  localparam logic [7:0] URS_OFS_FEATURE_ENABLE = 8'h1C;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] URS_SCRATCH_RST = 8'hFF;
  localparam logic [7:0] URS_CTRL_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int URS_IE_LINE = 2;
  localparam int URS_IE_MODEM = 3;
  localparam int URS_FE_ENHANCED = 4;
  localparam int URS_FE_AUTO_CTS = 7;
  localparam int URS_FC_SWAP = 6;
  localparam int URS_MC_DTR = 0;
  localparam int URS_MC_RTS = 1;
  localparam int URS_MC_OUT1 = 2;
  localparam int URS_MC_OUT2 = 3;
  localparam int URS_MC_LOOP = 4;
  // Write-side modem status bits 7:4, stored as 3:0
  localparam int URS_MF_TX_OFF = 0;
  localparam int URS_MF_RX_OFF = 1;
  localparam int URS_MF_NINE_BIT = 2;
  localparam int URS_MF_FAST_IR = 3;

  ////////////////////////////////////////////////////////////////////////
  // Infrared pulse widths in sixteenths of a bit time
  localparam logic [2:0] URS_IR_SLOW_PULSE = 3'h3;
  localparam logic [2:0] URS_IR_FAST_PULSE = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // Receive FIFO geometry
  localparam int URS_FIFO_DEPTH = 16;
  localparam logic [4:0] URS_FIFO_FULL = 5'h10;
  localparam logic [7:0] URS_BREAK_CHAR = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
    logic frame_err;
    logic brk;
  } urs_rx_char_s;

  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic bell_indication_in_n;
    logic carrier_detect_in_n;
  } urs_modem_pins_s;

  typedef struct packed {
    logic [4:0] fifo_count;
    logic shift_busy;
    logic hold_load;
    logic hold_to_shift;
  } urs_tx_stat_s;

  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    logic nine_bit;
    logic fast_ir;
    logic [2:0] ir_pulse_len;
    logic tx_may_start;
    logic dtr_n;
    logic rts_n;
  } urs_ctrl_s;

  // Alternating counter read pointer
  typedef enum logic [1:0] {
    URS_ALT_RX = 2'b01,
    URS_ALT_TX = 2'b10
  } urs_alt_e;

endpackage : urs_pkg

//--- logic/urs_rx_fifo.sv
// Receive FIFO holding each character with its parity, framing and
// break tags, plus a running count of tagged entries.
// Assumes the caller never relies on a push while full being stored.
`timescale 1ns/1ps
module urs_rx_fifo
  import urs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fifo_en_i,
  input wire logic push_i,
  input urs_pkg::urs_rx_char_s push_data_i,
  input wire logic pop_i,
  output urs_pkg::urs_rx_char_s head_o,
  output logic [4:0] count_o,
  output logic full_o,
  output logic empty_o,
  output logic err_any_o
);
  import urs_pkg::*;

  typedef struct packed {
    urs_rx_char_s [URS_FIFO_DEPTH-1:0] mem;
    logic [3:0] wp;
    logic [3:0] rp;
    logic [4:0] cnt;
    logic [4:0] errs;
  } urs_fifo_state_s;

  urs_fifo_state_s s_reg;
  urs_fifo_state_s s_next;
  logic do_push;
  logic do_pop;

  function automatic logic has_tag(input urs_rx_char_s c);
    return c.parity_err | c.frame_err | c.brk;
  endfunction : has_tag

  ////////////////////////////////////////////////////////////////////////
  // Without FIFO mode only one character is held
  assign full_o = fifo_en_i ? (s_reg.cnt == URS_FIFO_FULL)
                            : (s_reg.cnt != 5'h00);
  assign empty_o = (s_reg.cnt == 5'h00);
  assign head_o = s_reg.mem[s_reg.rp];
  assign count_o = s_reg.cnt;
  assign err_any_o = (s_reg.errs != 5'h00);
  assign do_push = push_i & ~full_o;
  assign do_pop = pop_i & ~empty_o;

  always_comb
  begin
    s_next = s_reg;
    if (do_push)
    begin
      s_next.mem[s_reg.wp] = push_data_i;
      s_next.wp = s_reg.wp + 4'h1;
    end
    if (do_pop)
    begin
      s_next.rp = s_reg.rp + 4'h1;
    end
    unique case ({do_push, do_pop})
      2'b10: s_next.cnt = s_reg.cnt + 5'h01;
      2'b01: s_next.cnt = s_reg.cnt - 5'h01;
      default: s_next.cnt = s_reg.cnt;
    endcase
    // Tagged-entry tally drives the FIFO error summary
    unique case ({do_push & has_tag(push_data_i), do_pop & has_tag(head_o)})
      2'b10: s_next.errs = s_reg.errs + 5'h01;
      2'b01: s_next.errs = s_reg.errs - 5'h01;
      default: s_next.errs = s_reg.errs;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule : urs_rx_fifo

//--- logic/urs_status.sv
// Line status, modem status, write-side modem features, scratch and
// FIFO level counter logic of a UART, behind a classic Wishbone slave.
// Assumes a receiver, transmitter and break-frame bit tick outside.
//
// Summary of operation
// - Data ready flag is set while any received character remains.
// - Character arriving with FIFO full sets overrun; FIFO stays intact.
// - Parity error flag follows the character ready for reading.
// - Framing error flag follows the character ready for reading.
// - Input low a full frame: flag break, store one break char.
// - Without FIFO, holding-empty sets on shift load, clears on write.
// - With FIFO, holding-empty is set exactly while transmit FIFO empty.
// - Transmitter empty only when holding and shift stages both empty.
// - FIFO error summary set while any stored byte carries a tag.
// - Line interrupt: overrun at once, error tags at read position.
// - Change flags for clear-to-send, set-ready, carrier; modem interrupt.
// - Ring change flag set only on pin rising, ending ringing.
// - Outside loopback, upper status bits are inverted modem pins.
// - In loopback, upper status bits come from modem control bits.
// - Auto clear-to-send: pin high stops next character, low resumes.
// - Enhanced mode: feature bits 4 and 5 disable transmitter, receiver.
// - Enhanced mode: feature bit 6 selects 9-bit multidrop operation.
// - Enhanced mode: feature bit 7 picks infrared pulse: 3/16 or 1/4 bit.
// - Scratch register is 8 bits and resets to all ones.
// - With swap bit set, scratch writes go to count mode register.
// - Mode bits pick receive, transmit or alternating level count.
// - Alternating mode: first read receive, then transmit, alternating.
// - With swap set, scratch reads return the selected FIFO level.
`timescale 1ns/1ps
module urs_status
  import urs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receiver side
  input wire logic fifo_en_i,
  input wire logic rx_char_valid_i,
  input urs_pkg::urs_rx_char_s rx_char_i,
  input wire logic rx_serial_i,
  input wire logic bit_tick_i,
  input wire logic [3:0] frame_bits_i,
  // Transmitter side
  input urs_pkg::urs_tx_stat_s tx_stat_i,
  // Modem pins
  input urs_pkg::urs_modem_pins_s modem_pins_i,
  // Control and interrupt requests
  output urs_pkg::urs_ctrl_s ctrl_o,
  output logic line_irq_o,
  output logic modem_irq_o
);
  import urs_pkg::*;

  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic [7:0] scratch_reg;
    logic [7:0] fifo_count_mode_reg;
    logic [7:0] modem_ctrl_reg;
    logic [7:0] irq_enable_reg;
    logic [7:0] feature_ctrl_reg;
    logic [7:0] feature_enable_reg;
    logic [3:0] mfeat;
    logic overrun;
    logic thre;
    logic [3:0] delta;
    logic [3:0] mstat_prev;
    logic primed;
    logic [3:0] brk_cnt;
    logic brk_hold;
    urs_alt_e alt;
    urs_ctrl_s ctrl;
  } urs_state_s;

  urs_state_s s_reg;
  urs_state_s s_next;

  logic access;
  logic wr;
  logic rd;
  logic enhanced;
  logic loopback;
  logic swap;
  logic [3:0] mstat;
  logic [3:0] change;
  logic [3:0] mfeat_eff;
  logic rdy;
  logic thre_eff;
  logic temt;
  logic brk_bit;
  logic [7:0] line_status_reg;
  logic [7:0] modem_status_reg;
  logic [7:0] level_count;
  logic rx_push;
  urs_rx_char_s rx_push_data;
  logic rx_pop;
  urs_rx_char_s rx_head;
  logic [4:0] rx_count;
  logic rx_full;
  logic rx_empty;
  logic rx_err_any;

  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction : hit

  function automatic logic [7:0] widen(input logic [4:0] cnt);
    return {3'h0, cnt};
  endfunction : widen

  ////////////////////////////////////////////////////////////////////////
  // Receive FIFO
  urs_rx_fifo u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fifo_en_i(fifo_en_i),
    .push_i(rx_push),
    .push_data_i(rx_push_data),
    .pop_i(rx_pop),
    .head_o(rx_head),
    .count_o(rx_count),
    .full_o(rx_full),
    .empty_o(rx_empty),
    .err_any_o(rx_err_any)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode; answer one cycle after the request is seen
  assign access = wb_cyc_i & wb_stb_i & ~s_reg.ack;
  assign wr = access & wb_we_i & wb_sel_i[0];
  assign rd = access & ~wb_we_i;
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = {24'h000000, s_reg.rdat};

  assign enhanced = s_reg.feature_enable_reg[URS_FE_ENHANCED];
  assign loopback = s_reg.modem_ctrl_reg[URS_MC_LOOP];
  assign swap = s_reg.feature_ctrl_reg[URS_FC_SWAP];
  assign mfeat_eff = s_reg.mfeat & {4{enhanced}};

  ////////////////////////////////////////////////////////////////////////
  // Modem status: bit 0 clear-to-send, 1 set-ready, 2 ring, 3 carrier
  assign mstat = loopback ?
    {s_reg.modem_ctrl_reg[URS_MC_OUT2],
     s_reg.modem_ctrl_reg[URS_MC_OUT1],
     s_reg.modem_ctrl_reg[URS_MC_DTR],
     s_reg.modem_ctrl_reg[URS_MC_RTS]} :
    ~{modem_pins_i.carrier_detect_in_n,
      modem_pins_i.bell_indication_in_n,
      modem_pins_i.dsr_n,
      modem_pins_i.cts_n};

  // Ring flag only when pin rises, i.e. status falls
  assign change = s_reg.primed ?
    {mstat[3] ^ s_reg.mstat_prev[3],
     s_reg.mstat_prev[2] & ~mstat[2],
     mstat[1] ^ s_reg.mstat_prev[1],
     mstat[0] ^ s_reg.mstat_prev[0]} : 4'h0;

  assign modem_status_reg = {mstat, s_reg.delta};

  ////////////////////////////////////////////////////////////////////////
  // Line status
  assign rdy = ~rx_empty;
  assign thre_eff = fifo_en_i ? (tx_stat_i.fifo_count == 5'h00)
                              : s_reg.thre;
  assign temt = thre_eff & ~tx_stat_i.shift_busy;
  assign brk_bit = (rdy & rx_head.brk) | s_reg.brk_hold;

  assign line_status_reg = {rx_err_any,
                            temt,
                            thre_eff,
                            brk_bit,
                            rdy & rx_head.frame_err,
                            rdy & rx_head.parity_err,
                            s_reg.overrun,
                            rdy};

  // Overrun at once; tag bits only once the character is at the head
  assign line_irq_o = s_reg.irq_enable_reg[URS_IE_LINE] &
    (s_reg.overrun |
     (rdy & (rx_head.parity_err | rx_head.frame_err |
             rx_head.brk)));
  assign modem_irq_o = s_reg.irq_enable_reg[URS_IE_MODEM] &
    (s_reg.delta != 4'h0);

  ////////////////////////////////////////////////////////////////////////
  // FIFO level counter selection
  always_comb
  begin
    if (~s_reg.fifo_count_mode_reg[0])
    begin
      level_count = widen(rx_count);
    end
    else if (~s_reg.fifo_count_mode_reg[1])
    begin
      level_count = widen(tx_stat_i.fifo_count);
    end
    else if (s_reg.alt == URS_ALT_RX)
    begin
      level_count = widen(rx_count);
    end
    else
    begin
      level_count = widen(tx_stat_i.fifo_count);
    end
  end

  assign ctrl_o = s_reg.ctrl;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    s_next = s_reg;
    s_next.ack = access;
    rx_push = 1'b0;
    rx_push_data = rx_char_i;
    rx_pop = 1'b0;

    // Break detection counts bit times while the line is low
    if (rx_serial_i)
    begin
      s_next.brk_cnt = 4'h0;
      s_next.brk_hold = 1'b0;
    end
    else if (bit_tick_i & ~s_reg.brk_hold)
    begin
      if (s_reg.brk_cnt + 4'h1 == frame_bits_i)
      begin
        s_next.brk_cnt = 4'h0;
        s_next.brk_hold = 1'b1;
        rx_push = ~mfeat_eff[URS_MF_RX_OFF];
        rx_push_data = '{data: URS_BREAK_CHAR, parity_err: 1'b0,
                         frame_err: 1'b0, brk: 1'b1};
      end
      else
      begin
        s_next.brk_cnt = s_reg.brk_cnt + 4'h1;
      end
    end
    if (~rx_push & rx_char_valid_i & ~s_reg.brk_hold &
        ~mfeat_eff[URS_MF_RX_OFF])
    begin
      rx_push = 1'b1;
    end
    // A full FIFO keeps its contents; the newcomer is dropped
    if (rx_push & rx_full)
    begin
      rx_push = 1'b0;
      s_next.overrun = 1'b1;
    end
    else if (rd & hit(wb_adr_i, URS_OFS_LINE_STATUS))
    begin
      s_next.overrun = 1'b0;
    end

    // Holding-empty: shift load sets and wins over host write
    s_next.thre = (s_reg.thre & ~tx_stat_i.hold_load) |
                  tx_stat_i.hold_to_shift;

    // Change flags: new changes win over the read clear
    s_next.delta = ((rd & hit(wb_adr_i, URS_OFS_MODEM_STATUS)) ?
                    4'h0 : s_reg.delta) | change;
    s_next.mstat_prev = mstat;
    s_next.primed = 1'b1;

    // Reads
    if (rd)
    begin
      s_next.rdat = 8'h00;
      if (hit(wb_adr_i, URS_OFS_RX_DATA))
      begin
        s_next.rdat = rdy ? rx_head.data : 8'h00;
        rx_pop = 1'b1;
      end
      else if (hit(wb_adr_i, URS_OFS_LINE_STATUS))
      begin
        s_next.rdat = line_status_reg;
      end
      else if (hit(wb_adr_i, URS_OFS_MODEM_STATUS))
      begin
        s_next.rdat = modem_status_reg;
      end
      else if (hit(wb_adr_i, URS_OFS_SCRATCH))
      begin
        s_next.rdat = swap ? level_count : s_reg.scratch_reg;
        if (swap & (s_reg.fifo_count_mode_reg[1:0] == 2'h3))
        begin
          s_next.alt = (s_reg.alt == URS_ALT_RX) ? URS_ALT_TX
                                                 : URS_ALT_RX;
        end
      end
      else if (hit(wb_adr_i, URS_OFS_MODEM_CTRL))
      begin
        s_next.rdat = s_reg.modem_ctrl_reg;
      end
      else if (hit(wb_adr_i, URS_OFS_IRQ_ENABLE))
      begin
        s_next.rdat = s_reg.irq_enable_reg;
      end
      else if (hit(wb_adr_i, URS_OFS_FEATURE_CTRL))
      begin
        s_next.rdat = s_reg.feature_ctrl_reg;
      end
      else if (hit(wb_adr_i, URS_OFS_FEATURE_ENABLE))
      begin
        s_next.rdat = s_reg.feature_enable_reg;
      end
    end

    // Writes
    if (wr)
    begin
      if (hit(wb_adr_i, URS_OFS_MODEM_STATUS) & enhanced)
      begin
        s_next.mfeat = wb_dat_i[7:4];
      end
      else if (hit(wb_adr_i, URS_OFS_SCRATCH))
      begin
        if (swap)
        begin
          s_next.fifo_count_mode_reg = wb_dat_i[7:0];
          s_next.alt = URS_ALT_RX;
        end
        else
        begin
          s_next.scratch_reg = wb_dat_i[7:0];
        end
      end
      else if (hit(wb_adr_i, URS_OFS_MODEM_CTRL))
      begin
        s_next.modem_ctrl_reg = wb_dat_i[7:0];
      end
      else if (hit(wb_adr_i, URS_OFS_IRQ_ENABLE))
      begin
        s_next.irq_enable_reg = wb_dat_i[7:0];
      end
      else if (hit(wb_adr_i, URS_OFS_FEATURE_CTRL))
      begin
        s_next.feature_ctrl_reg = wb_dat_i[7:0];
      end
      else if (hit(wb_adr_i, URS_OFS_FEATURE_ENABLE))
      begin
        s_next.feature_enable_reg = wb_dat_i[7:0];
      end
    end

    // Registered control outputs
    s_next.ctrl.tx_enable = ~mfeat_eff[URS_MF_TX_OFF];
    s_next.ctrl.rx_enable = ~mfeat_eff[URS_MF_RX_OFF];
    s_next.ctrl.nine_bit = mfeat_eff[URS_MF_NINE_BIT];
    s_next.ctrl.fast_ir = mfeat_eff[URS_MF_FAST_IR];
    s_next.ctrl.ir_pulse_len = mfeat_eff[URS_MF_FAST_IR] ?
      URS_IR_FAST_PULSE : URS_IR_SLOW_PULSE;
    // Checked only at a character start, so the current one completes
    s_next.ctrl.tx_may_start = ~mfeat_eff[URS_MF_TX_OFF] &
      ~(s_reg.feature_enable_reg[URS_FE_AUTO_CTS] & ~mstat[0]);
    s_next.ctrl.dtr_n = loopback | ~s_reg.modem_ctrl_reg[URS_MC_DTR];
    s_next.ctrl.rts_n = loopback | ~s_reg.modem_ctrl_reg[URS_MC_RTS];
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
      s_reg.scratch_reg <= URS_SCRATCH_RST;
      s_reg.fifo_count_mode_reg <= URS_CTRL_RST;
      s_reg.thre <= 1'b1;
      s_reg.alt <= URS_ALT_RX;
      s_reg.ctrl.tx_enable <= 1'b1;
      s_reg.ctrl.rx_enable <= 1'b1;
      s_reg.ctrl.ir_pulse_len <= URS_IR_SLOW_PULSE;
      s_reg.ctrl.tx_may_start <= 1'b1;
      s_reg.ctrl.dtr_n <= 1'b1;
      s_reg.ctrl.rts_n <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule : urs_status

//--- sim/urs_peer.sv
// Far-side model: modem pins, received characters and serial line.
// Assumes the bench calls its tasks; all changes follow a rising edge.
`timescale 1ns/1ps
module urs_peer
  import urs_pkg::*;
(
  input wire logic clk_i,
  output urs_pkg::urs_modem_pins_s pins_o,
  output logic valid_o,
  output urs_pkg::urs_rx_char_s char_o,
  output logic serial_o,
  output logic tick_o
);
  logic [1:0] div = 2'h0;
  initial
  begin
    pins_o = 4'hF;
    valid_o = 1'b0;
    char_o = '0;
    serial_o = 1'b1;
  end
  always @(posedge clk_i) div <= div + 2'h1;
  assign tick_o = (div == 2'h3);
  ////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] d, input logic pe, input logic fe);
    @(posedge clk_i);
    valid_o <= 1'b1;
    char_o <= {d, pe, fe, 1'b0};
    @(posedge clk_i);
    valid_o <= 1'b0;
    // Stale data never left on the bus
    char_o <= {~d, ~pe, ~fe, 1'b1};
  endtask : send
  task automatic set_pins(input logic [3:0] p);
    @(posedge clk_i);
    pins_o <= p;
  endtask : set_pins
  task automatic brk(input int n);
    int k;
    k = 0;
    @(posedge clk_i);
    serial_o <= 1'b0;
    while (k < n)
    begin
      @(posedge clk_i);
      if (tick_o) k++;
    end
  endtask : brk
  task automatic idle();
    @(posedge clk_i);
    serial_o <= 1'b1;
  endtask : idle
endmodule : urs_peer

//--- sim/urs_status_properties.sv
// Checker on the status block's bus, control and interrupt outputs.
// Assumes it is bound to every urs_status instance.
`timescale 1ns/1ps
module urs_status_chk
  import urs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic fifo_en_i,
  input wire logic rx_char_valid_i,
  input urs_pkg::urs_rx_char_s rx_char_i,
  input wire logic rx_serial_i,
  input wire logic bit_tick_i,
  input wire logic [3:0] frame_bits_i,
  input urs_pkg::urs_tx_stat_s tx_stat_i,
  input urs_pkg::urs_modem_pins_s modem_pins_i,
  input urs_pkg::urs_ctrl_s ctrl_o,
  input wire logic line_irq_o,
  input wire logic modem_irq_o
);
  logic ls_rd;
  assign ls_rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
    && wb_adr_i == URS_OFS_LINE_STATUS && fifo_en_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  a_ack_timing: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack not one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_irq_reset: assert property ($fell(rst_i) |-> !line_irq_o
    && !modem_irq_o) else $error("interrupt after reset");
  a_ctrl_reset: assert property ($fell(rst_i) |-> ctrl_o.tx_enable
    && ctrl_o.rx_enable && !ctrl_o.nine_bit && !ctrl_o.fast_ir)
    else $error("control outputs wrong after reset");
  a_ir_fast: assert property (ctrl_o.fast_ir
    |-> ctrl_o.ir_pulse_len == URS_IR_FAST_PULSE)
    else $error("fast infrared pulse width wrong");
  a_ir_slow: assert property (!ctrl_o.fast_ir
    |-> ctrl_o.ir_pulse_len == URS_IR_SLOW_PULSE)
    else $error("slow infrared pulse width wrong");
  a_thre_fifo: assert property (ls_rd && $stable(tx_stat_i)
    |=> wb_dat_o[5] == ($past(tx_stat_i.fifo_count) == 5'h00))
    else $error("holding empty flag wrong in fifo mode");
  a_temt_fifo: assert property (ls_rd && $stable(tx_stat_i)
    |=> wb_dat_o[6] == ($past(tx_stat_i.fifo_count) == 5'h00
    && !$past(tx_stat_i.shift_busy)))
    else $error("transmitter empty flag wrong in fifo mode");
endmodule : urs_status_chk
bind urs_status urs_status_chk u_chk (.*);

//--- sim/tb.sv
// Self-checking bench for the line and modem status block.
// Assumes the far-side model urs_peer and the bound checker.
`timescale 1ns/1ps
module tb;
  import urs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fifo_en = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [7:0] q;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, lirq, mirq, valid, ser, tick;
  urs_rx_char_s ch;
  urs_modem_pins_s pins;
  urs_tx_stat_s txs = '0;
  urs_ctrl_s ctrl;
  int failures = 0, samples_checked = 0;
  always #2 clk_i = ~clk_i;
  urs_peer peer (.clk_i(clk_i), .pins_o(pins), .valid_o(valid),
    .char_o(ch), .serial_o(ser), .tick_o(tick));
  urs_status dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .fifo_en_i(fifo_en),
    .rx_char_valid_i(valid), .rx_char_i(ch), .rx_serial_i(ser),
    .bit_tick_i(tick), .frame_bits_i(4'hA), .tx_stat_i(txs),
    .modem_pins_i(pins), .ctrl_o(ctrl), .line_irq_o(lirq),
    .modem_irq_o(mirq));
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rc(input string nm, input logic [7:0] a,
    input logic [7:0] m, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(nm, e, q & m);
  endtask : rc
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rc("scratch", 8'h0C, 8'hFF, 8'hFF);
    rc("line", 8'h04, 8'hFF, 8'h60);
    rc("modem", 8'h08, 8'hFF, 8'h00);
    rc("unmapped", 8'h20, 8'hFF, 8'h00);
    chk("ctrl", 8'hC7, ctrl[9:2]);
    wb(1'b1, 8'h0C, 8'h5A);
    rc("scratch", 8'h0C, 8'hFF, 8'h5A);
    sel <= 4'hE;
    wb(1'b1, 8'h0C, 8'h33);
    sel <= 4'hF;
    rc("scratch_sel", 8'h0C, 8'hFF, 8'h5A);
  endtask : t_reset
  task automatic t_ovr();
    fifo_en <= 1'b0;
    wb(1'b1, 8'h14, 8'h04);
    peer.send(8'hA1, 1'b0, 1'b0);
    peer.send(8'hA2, 1'b0, 1'b0);
    tk(2);
    chk("line_irq", 8'h01, {7'h0, lirq});
    rc("line", 8'h04, 8'h03, 8'h03);
    tk(1);
    chk("line_irq", 8'h00, {7'h0, lirq});
    rc("line", 8'h04, 8'h03, 8'h01);
    rc("rx", 8'h00, 8'hFF, 8'hA1);
    rc("line", 8'h04, 8'h01, 8'h00);
  endtask : t_ovr
  task automatic t_thre();
    txs.hold_load <= 1'b1;
    txs.shift_busy <= 1'b1;
    tk(1);
    txs.hold_load <= 1'b0;
    rc("thre", 8'h04, 8'h60, 8'h00);
    txs.hold_to_shift <= 1'b1;
    tk(1);
    txs.hold_to_shift <= 1'b0;
    rc("thre", 8'h04, 8'h60, 8'h20);
    txs.shift_busy <= 1'b0;
    rc("temt", 8'h04, 8'h60, 8'h60);
  endtask : t_thre
  task automatic t_rx();
    fifo_en <= 1'b1;
    peer.send(8'h11, 1'b0, 1'b0);
    peer.send(8'h22, 1'b1, 1'b0);
    peer.send(8'h33, 1'b0, 1'b1);
    tk(2);
    rc("line", 8'h04, 8'hFF, 8'hE1);
    chk("line_irq", 8'h00, {7'h0, lirq});
    rc("rx", 8'h00, 8'hFF, 8'h11);
    rc("line", 8'h04, 8'hFF, 8'hE5);
    chk("line_irq", 8'h01, {7'h0, lirq});
    rc("rx", 8'h00, 8'hFF, 8'h22);
    rc("line", 8'h04, 8'hFF, 8'hE9);
    rc("rx", 8'h00, 8'hFF, 8'h33);
    rc("line", 8'h04, 8'hFF, 8'h60);
  endtask : t_rx
  task automatic t_modem();
    wb(1'b1, 8'h14, 8'h08);
    peer.set_pins(4'b0111);
    tk(4);
    chk("modem_irq", 8'h01, {7'h0, mirq});
    rc("modem", 8'h08, 8'hFF, 8'h11);
    rc("modem", 8'h08, 8'hFF, 8'h10);
    chk("modem_irq", 8'h00, {7'h0, mirq});
    peer.set_pins(4'b0101);
    tk(4);
    rc("modem", 8'h08, 8'hFF, 8'h50);
    peer.set_pins(4'b0111);
    tk(4);
    rc("modem", 8'h08, 8'hFF, 8'h14);
    peer.set_pins(4'b0010);
    tk(4);
    rc("modem", 8'h08, 8'hFF, 8'hBA);
    wb(1'b1, 8'h10, 8'h15);
    rc("modem", 8'h08, 8'hF0, 8'h60);
    chk("loop_pins", 8'h03, {6'h0, ctrl.dtr_n, ctrl.rts_n});
    wb(1'b1, 8'h10, 8'h03);
    tk(1);
    chk("modem_pins", 8'h00, {6'h0, ctrl.dtr_n, ctrl.rts_n});
  endtask : t_modem
  task automatic t_feat();
    wb(1'b1, 8'h08, 8'hF0);
    tk(1);
    chk("ctrl", 8'hC7, ctrl[9:2]);
    wb(1'b1, 8'h1C, 8'h10);
    wb(1'b1, 8'h08, 8'hF0);
    tk(1);
    chk("ctrl", 8'h38, ctrl[9:2] & 8'hFE);
    wb(1'b1, 8'h08, 8'h00);
    tk(1);
    chk("ctrl", 8'hC7, ctrl[9:2]);
    wb(1'b1, 8'h1C, 8'h90);
    tk(1);
    chk("ctrl", 8'hC7, ctrl[9:2]);
    peer.set_pins(4'b1010);
    tk(4);
    chk("ctrl", 8'hC6, ctrl[9:2]);
  endtask : t_feat
  task automatic t_count();
    int i;
    txs.fifo_count <= 5'h05;
    for (i = 1; i < 4; i++) peer.send(8'(i), 1'b0, 1'b0);
    wb(1'b1, 8'h18, 8'h40);
    wb(1'b1, 8'h0C, 8'h00);
    rc("level", 8'h0C, 8'hFF, 8'h03);
    wb(1'b1, 8'h0C, 8'h02);
    rc("level", 8'h0C, 8'hFF, 8'h03);
    rc("line", 8'h04, 8'h60, 8'h00);
    wb(1'b1, 8'h0C, 8'h01);
    rc("level", 8'h0C, 8'hFF, 8'h05);
    wb(1'b1, 8'h0C, 8'h03);
    rc("level", 8'h0C, 8'hFF, 8'h03);
    rc("level", 8'h0C, 8'hFF, 8'h05);
    rc("level", 8'h0C, 8'hFF, 8'h03);
    wb(1'b1, 8'h18, 8'h00);
    rc("scratch", 8'h0C, 8'hFF, 8'h5A);
    txs.fifo_count <= 5'h00;
    for (i = 1; i < 4; i++) rc("rx", 8'h00, 8'hFF, 8'(i));
  endtask : t_count
  task automatic t_brk();
    peer.brk(12);
    tk(2);
    rc("line", 8'h04, 8'hFF, 8'hF1);
    rc("rx", 8'h00, 8'hFF, 8'h00);
    rc("line", 8'h04, 8'hFF, 8'h70);
    peer.idle();
    tk(2);
    rc("line", 8'h04, 8'hFF, 8'h60);
  endtask : t_brk
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_ovr();
    t_thre();
    t_rx();
    t_modem();
    t_feat();
    t_count();
    t_brk();
    final_report();
  end
  // Cut a hung handshake short
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    final_report();
  end
endmodule : tb
